// ---- asa_hold_timer.sv ----
`timescale 1ns/100ps
module asa_hold_timer #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	// Counts down to zero and rests there
	assign nxt_count = load ? load_val :
		(count_ff != '0) ? count_ff - W'(1) : count_ff;
	assign done = (count_ff == '0);

	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule // asa_hold_timer

// ---- asa_pkg.sv ----
package asa_pkg;

	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	localparam int WORDS = 2097152;
	localparam int TMR_W = 4;

	// Clock and the slow grade's figures, in ns; they also cover the fast grade
	localparam int T_CLK_NS = 20;
	localparam int T_ACC_NS = 17;
	localparam int T_CYCLE_NS = 17;
	localparam int T_FLOAT_NS = 8;
	localparam int T_WHZ_NS = 8;
	localparam int T_WP_NS = 11;
	localparam int T_DW_NS = 8;
	localparam int T_DH_NS = 0;
	localparam int T_WR_NS = 1;

	function automatic int cyc_up(input int t_ns);
		int c;
		c = (t_ns + T_CLK_NS - 1) / T_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ACC_CYC = cyc_up(T_ACC_NS);
	localparam int CYCLE_CYC = cyc_up(T_CYCLE_NS);
	localparam int FLOAT_CYC = cyc_up(T_FLOAT_NS);
	localparam int WHZ_CYC = cyc_up(T_WHZ_NS);
	localparam int WP_CYC = cyc_up(T_WP_NS);
	localparam int DW_CYC = cyc_up(T_DW_NS);
	localparam int WR_CYC = cyc_up(T_WR_NS);

	localparam logic [TMR_W-1:0] ACC_LOAD = TMR_W'(ACC_CYC - 1);
	localparam logic [TMR_W-1:0] FLOAT_LOAD = TMR_W'(FLOAT_CYC - 1);
	localparam logic [TMR_W-1:0] WHZ_LOAD = TMR_W'(WHZ_CYC - 1);
	localparam logic [TMR_W-1:0] DW_LOAD = TMR_W'(DW_CYC - 1);
	localparam logic [TMR_W-1:0] WR_LOAD = TMR_W'(WR_CYC - 1);
	localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
	localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_ACC,
		ST_RD_FLOAT,
		ST_WR_FLOAT,
		ST_WR_DATA,
		ST_WR_RECOV
	} asa_state_type;

endpackage

// ---- asa_sram_host.sv ----
// How it works
// - Output enable high releases data lines
// - Strobe stays high through every read
// - Address valid by select falling edge
// - Address changes only with strobe high
// - Host never drives while memory drives
// - Host waits out float time after strobe falls
// - Address, select, strobe low meet write minimum
// - Write data set up before write end
`timescale 1ns/100ps
module asa_sram_host (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic req_write,
	input wire logic [asa_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asa_pkg::DATA_W-1:0] req_wdata,
	output logic ready,
	output logic [asa_pkg::DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic [asa_pkg::ADDR_W-1:0] word_address,
	output logic sel_n,
	output logic write_strobe_n,
	output logic out_enable_n,
	input wire logic [asa_pkg::DATA_W-1:0] bidir_data_lines_i,
	output logic [asa_pkg::DATA_W-1:0] bidir_data_lines_o,
	output logic bidir_data_lines_oe
);
	import asa_pkg::*;

	asa_state_type state_ff, nxt_state;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic sel_n_ff, nxt_sel_n;
	logic we_n_ff, nxt_we_n;
	logic oe_n_ff, nxt_oe_n;
	logic doe_ff, nxt_doe;
	logic ready_ff, nxt_ready;
	logic rvalid_ff, nxt_rvalid;
	logic tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic tmr_done;
	logic take;

	////////////////////////////////////////////////////////////////////////
	// Wait states

	asa_hold_timer #(.W(TMR_W)) u_timer (
		.clk(clk),
		.rst(rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	assign take = req && ready_ff && (state_ff == ST_IDLE);

	always_comb begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_sel_n = sel_n_ff;
		nxt_we_n = we_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_doe = doe_ff;
		nxt_rvalid = 1'b0;
		tmr_load = 1'b0;
		tmr_val = TMR_ZERO;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					// Address and select change on the same edge
					nxt_addr = req_addr;
					nxt_wdata = req_wdata;
					nxt_sel_n = 1'b0;
					tmr_load = 1'b1;
					if (req_write) begin
						// Zero setup: strobe falls with the address
						nxt_we_n = 1'b0;
						nxt_state = ST_WR_FLOAT;
						tmr_val = WHZ_LOAD;
					end else begin
						nxt_oe_n = 1'b0;
						nxt_state = ST_RD_ACC;
						tmr_val = ACC_LOAD;
					end
				end
			end
			ST_RD_ACC: begin
				if (tmr_done) begin
					// Sampled before select rises, so hold time is not needed
					nxt_rdata = bidir_data_lines_i;
					nxt_rvalid = 1'b1;
					nxt_sel_n = 1'b1;
					nxt_oe_n = 1'b1;
					tmr_load = 1'b1;
					tmr_val = FLOAT_LOAD;
					nxt_state = ST_RD_FLOAT;
				end
			end
			ST_RD_FLOAT: begin
				if (tmr_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_WR_FLOAT: begin
				// Lines may still be memory outputs until float time ends
				if (tmr_done) begin
					nxt_doe = 1'b1;
					tmr_load = 1'b1;
					tmr_val = DW_LOAD;
					nxt_state = ST_WR_DATA;
				end
			end
			ST_WR_DATA: begin
				if (tmr_done) begin
					nxt_we_n = 1'b1;
					nxt_sel_n = 1'b1;
					tmr_load = 1'b1;
					tmr_val = WR_LOAD;
					nxt_state = ST_WR_RECOV;
				end
			end
			ST_WR_RECOV: begin
				// Data and address held one more cycle past write end
				if (tmr_done) begin
					nxt_doe = 1'b0;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_sel_n = 1'b1;
				nxt_we_n = 1'b1;
				nxt_oe_n = 1'b1;
				nxt_doe = 1'b0;
			end
		endcase
	end

	assign nxt_ready = (nxt_state == ST_IDLE);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			addr_ff <= 21'h000000;
			wdata_ff <= 8'h00;
			rdata_ff <= 8'h00;
			sel_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			doe_ff <= 1'b0;
			ready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			sel_n_ff <= nxt_sel_n;
			we_n_ff <= nxt_we_n;
			oe_n_ff <= nxt_oe_n;
			doe_ff <= nxt_doe;
			ready_ff <= nxt_ready;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign word_address = addr_ff;
	assign sel_n = sel_n_ff;
	assign write_strobe_n = we_n_ff;
	assign out_enable_n = oe_n_ff;
	assign bidir_data_lines_o = wdata_ff;
	assign bidir_data_lines_oe = doe_ff;
	assign ready = ready_ff;
	assign rd_data = rdata_ff;
	assign rd_valid = rvalid_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_strobe_high_read: assert property (
		@(posedge clk) disable iff (rst)
		!oe_n_ff |-> we_n_ff)
		else $error("strobe low during read");

	a_no_contention: assert property (
		@(posedge clk) disable iff (rst)
		doe_ff |-> oe_n_ff && $past(oe_n_ff))
		else $error("host drives while memory may drive");

	a_float_wait: assert property (
		@(posedge clk) disable iff (rst)
		$fell(we_n_ff) |-> !doe_ff ##1 (doe_ff && !we_n_ff))
		else $error("data driven inside float time");

	a_addr_stable_wr: assert property (
		@(posedge clk) disable iff (rst)
		!we_n_ff && !$past(we_n_ff) |-> $stable(addr_ff))
		else $error("address moved during write");

	a_addr_stable_rd: assert property (
		@(posedge clk) disable iff (rst)
		!sel_n_ff && !$past(sel_n_ff) |-> $stable(addr_ff))
		else $error("address moved while selected");

	a_write_pulse: assert property (
		@(posedge clk) disable iff (rst)
		$fell(we_n_ff) |-> !we_n_ff && !sel_n_ff ##1 !we_n_ff && !sel_n_ff)
		else $error("write pulse too short");

	a_data_setup_hold: assert property (
		@(posedge clk) disable iff (rst)
		$rose(we_n_ff) |-> $past(doe_ff) && doe_ff && $stable(wdata_ff))
		else $error("write data not around write end");

	a_recovery: assert property (
		@(posedge clk) disable iff (rst)
		$rose(we_n_ff) |-> $stable(addr_ff) ##1 sel_n_ff)
		else $error("write recovery violated");

	a_read_sample: assert property (
		@(posedge clk) disable iff (rst)
		rvalid_ff |-> !$past(oe_n_ff) && !$past(sel_n_ff) && oe_n_ff)
		else $error("read data taken outside access");

	a_read_spacing: assert property (
		@(posedge clk) disable iff (rst)
		$rose(sel_n_ff) |-> sel_n_ff ##1 sel_n_ff)
		else $error("cycles not spaced");
endmodule // asa_sram_host

// ---- asa_sram_model.sv ----
`timescale 1ns/100ps
module asa_sram_model (
	input wire logic [asa_pkg::ADDR_W-1:0] word_address,
	input wire logic sel_n,
	input wire logic write_strobe_n,
	input wire logic out_enable_n,
	input wire logic [asa_pkg::DATA_W-1:0] data_in,
	output logic [asa_pkg::DATA_W-1:0] data_out,
	output logic drive
);
	import asa_pkg::*;
	// Sparse store; a full array of 2M words would be wasteful
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] word;
	wire wr_act = ~sel_n & ~write_strobe_n;
	wire rd_act = ~sel_n & write_strobe_n & ~out_enable_n;
	////////////////////////////////////////////////////////////////////////
	always @(negedge wr_act) begin
		mem[int'(word_address)] = data_in;
	end
	always @(rd_act or word_address) begin
		if (mem.exists(int'(word_address)))
			word = mem[int'(word_address)];
		else
			word = word_address[7:0] ^ 8'h5A;
	end
	// Late enough for the 3 ns minima, early for the 7 ns maxima
	assign #3 drive = rd_act;
	// Released lines show the inverse, never a stale copy
	assign #3 data_out = rd_act ? word : ~word;
endmodule // asa_sram_model

// ---- async_sram_2m_by_8_access_bench.sv ----
`timescale 1ns/100ps
module async_sram_2m_by_8_access_bench;
	import asa_pkg::*;
	typedef struct {logic w; logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} asa_row_type;
	logic clk, rst, req, req_write, ready, rd_valid, sel_n, write_strobe_n;
	logic out_enable_n, oe, drive;
	logic [ADDR_W-1:0] req_addr, word_address;
	logic [DATA_W-1:0] req_wdata, rd_data, d_o, d_m, d_i;
	int mismatches, total_checks, cycles;
	asa_row_type rows [7] = '{'{1, 21'h0, 8'h3C, 8'h0},
		'{1, 21'h1FFFFF, 8'hC3, 8'h0}, '{0, 21'h0, 8'h0, 8'h3C},
		'{0, 21'h1FFFFF, 8'h0, 8'hC3}, '{0, 21'h55, 8'h0, 8'h0F},
		'{1, 21'h0, 8'hAA, 8'h0}, '{0, 21'h0, 8'h0, 8'hAA}};
	assign d_i = oe ? d_o : d_m;
	asa_sram_host DUT (.clk(clk), .rst(rst), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.ready(ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.word_address(word_address), .sel_n(sel_n),
		.write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
		.bidir_data_lines_i(d_i), .bidir_data_lines_o(d_o),
		.bidir_data_lines_oe(oe));
	asa_sram_model MEM (.word_address(word_address), .sel_n(sel_n),
		.write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
		.data_in(d_i), .data_out(d_m), .drive(drive));
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [ADDR_W-1:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic op(input asa_row_type r);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		// A request raised while busy would be dropped
		while (ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		req = 1'b1;
		req_write = r.w;
		req_addr = r.a;
		req_wdata = r.d;
		@(posedge clk);
		#1;
		req = 1'b0;
		cmp(word_address, r.a);
		cmp(21'({sel_n, write_strobe_n, out_enable_n}), 21'(r.w ? 1 : 2));
		while (ready !== 1'b1 && n < 8) begin
			if (n == 0) cmp(21'(oe), 21'h0);
			if (n == 1 && r.w) cmp(21'({oe, d_o}), 21'({1'b1, r.d}));
			if (rd_valid === 1'b1) begin
				seen = 1'b1;
				cmp(21'(rd_data), 21'(r.e));
			end
			@(posedge clk);
			#1;
			n++;
		end
		cmp(21'(n), 21'(r.w ? 3 : 2));
		cmp(21'(seen), 21'(!r.w));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard; the whole run needs well under 200 cycles
	always @(posedge clk) begin
		cycles++;
		if (drive === 1'b1 && oe === 1'b1) cmp(21'(oe), 21'h0);
		if (cycles == 3000) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		rst = 1'b1;
		req = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		repeat (8) @(posedge clk);
		#1;
		cmp(21'({sel_n, write_strobe_n, out_enable_n, oe, ready, rd_valid}),
			21'h3A);
		rst = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			op(rows[i]);
			$display("row %0d done", i);
		end
		// Reset in mid-write must release every control at once
		req = 1'b1;
		req_write = 1'b1;
		req_addr = 21'h7;
		@(posedge clk);
		#1;
		req = 1'b0;
		rst = 1'b1;
		// Two edges, so the checks see only reset values as history
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		cmp(21'({sel_n, write_strobe_n, out_enable_n, oe, ready}), 21'h1D);
		cmp(21'(rd_data), 21'h0);
		$display("mid reset test done");
		// Requests while busy are dropped, so word 5 stays unwritten
		req = 1'b1;
		req_addr = 21'h9;
		req_wdata = 8'h11;
		@(posedge clk);
		#1;
		req_addr = 21'h5;
		req_wdata = 8'h99;
		repeat (2) @(posedge clk);
		#1;
		req = 1'b0;
		op('{1'b0, 21'h9, 8'h0, 8'h11});
		op('{1'b0, 21'h5, 8'h0, 8'h5F});
		$display("busy test done");
		close_out();
	end
endmodule // async_sram_2m_by_8_access_bench
